// >>> watchdog_regs.svh
// Register offsets, field positions, reset values and counts of the independent watchdog.
`ifndef WATCHDOG_REGS_SVH
`define WATCHDOG_REGS_SVH

`define WDG_CTRL_OFFSET 12'h000
`define WDG_KEY_MSB 15
`define WDG_KEY_LSB 12
`define WDG_EN_BIT 8
`define WDG_CKSEL_BIT 6
`define WDG_STDBY_FRZ_BIT 5
`define WDG_STOP_FRZ_BIT 4
`define WDG_PR_MSB 2
`define WDG_PR_LSB 0
`define WDG_KEY_VALUE 4'ha
`define WDG_COUNT_W 12
`define WDG_COUNT_INIT 12'hfff
`define WDG_COUNT_ZERO 12'h000
`define WDG_PR_RESET 3'h0
`define WDG_RDATA_RESET 32'h0000_0000
`define WDG_PRESC_W 8

`endif

// >>> watchdog_pkg.sv
// Types shared by the independent watchdog and its prescaler.
`include "watchdog_regs.svh"

package watchdog_pkg;

  typedef enum logic [1:0] {
    MODE_IDLE = 2'b00,
    MODE_COUNT = 2'b01,
    MODE_HOLD = 2'b10,
    MODE_FIRED = 2'b11
  } wd_mode_e;

  typedef struct packed {
    logic en;
    logic stop_cksel;
    logic stdby_frz;
    logic stop_frz;
    logic [2:0] presc;
  } ctrl_s;

  typedef struct packed {
    logic int_s1;
    logic int_s2;
    logic int_s3;
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
    ctrl_s ctrl;
    logic [`WDG_COUNT_W-1:0] count;
    wd_mode_e mode;
    logic [31:0] rdata;
  } wd_state_s;

  typedef struct packed {
    logic [`WDG_PRESC_W-1:0] cnt;
    logic step;
  } presc_state_s;

endpackage : watchdog_pkg

// >>> presc_if.sv
// Link between the watchdog core and its prescaler.
`timescale 1ns/10ps

interface presc_if;
  logic src_tick;
  logic run;
  logic restart;
  logic [2:0] sel;
  logic step;

  modport ctrl (
    output src_tick,
    output run,
    output restart,
    output sel,
    input step
  );

  modport presc (
    input src_tick,
    input run,
    input restart,
    input sel,
    output step
  );
endinterface : presc_if

// >>> watchdog_prescaler.sv
// Selectable divide-by-2 to divide-by-256 prescaler feeding the watchdog counter.
`timescale 1ns/10ps
`include "watchdog_regs.svh"

module watchdog_prescaler #(
  parameter int PRESC_W = `WDG_PRESC_W
) (
  input wire logic sys_clk,
  input wire logic reset,
  presc_if.presc bus
);

  watchdog_pkg::presc_state_s st_r;
  watchdog_pkg::presc_state_s st_nxt;
  logic [PRESC_W:0] limit_wide;
  logic [PRESC_W-1:0] limit;

  ////////////////////////////////////////////////////////////////////////////////
  // Division limit: code n divides by 2 to the power n+1.

  always_comb
  begin
    limit_wide = ((PRESC_W+1)'(2) << bus.sel) - (PRESC_W+1)'(1);
    limit = limit_wide[PRESC_W-1:0];
  end

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.step = 1'b0;
    if (bus.restart)
    begin
      st_nxt.cnt = '0;
    end
    else if (bus.run && bus.src_tick)
    begin
      if (st_r.cnt >= limit)
      begin
        st_nxt.cnt = '0;
        st_nxt.step = 1'b1;
      end
      else
      begin
        st_nxt.cnt = st_r.cnt + PRESC_W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign bus.step = st_r.step;

  ////////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  AST_PRESC_STEP_AT_LIMIT: assert property (
    bus.step |-> ($past(st_r.cnt) >= $past(limit)) && $past(bus.src_tick) && $past(bus.run))
  else $error("prescaler stepped before its division limit");

  AST_PRESC_RESTART_CLEARS: assert property (
    bus.restart |=> (st_r.cnt == '0) && !bus.step)
  else $error("prescaler restart did not clear the division count");

endmodule : watchdog_prescaler

// >>> independent_watchdog.sv
// Independent watchdog: control register on the peripheral bus, slow clock pick, 12-bit down-counter.
`timescale 1ns/10ps
`include "watchdog_regs.svh"

module independent_watchdog (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic internal_slow_osc,
  input wire logic external_slow_osc,
  input wire logic stop_mode,
  input wire logic standby_mode,
  input wire logic debug_halt,
  input wire logic debug_halt_counter,
  input wire logic hw_start_option,
  output logic watchdog_reset_req,
  output logic [`WDG_COUNT_W-1:0] count_value
);

  watchdog_pkg::wd_state_s st_r;
  watchdog_pkg::wd_state_s st_nxt;
  logic addr_hit;
  logic wr_acc;
  logic key_hit;
  logic enabled;
  logic frozen;
  logic use_ext;
  logic int_tick;
  logic ext_tick;
  logic [31:0] rd_word;

  presc_if presc_link ();

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode and read word.

  always_comb
  begin
    addr_hit = (paddr == `WDG_CTRL_OFFSET);
    wr_acc = psel && penable && pwrite && addr_hit;
    key_hit = wr_acc && (pwdata[`WDG_KEY_MSB:`WDG_KEY_LSB] == `WDG_KEY_VALUE);
    enabled = st_r.ctrl.en || hw_start_option;
    // A halted core must not be reset by a counter it cannot service, when so chosen.
    frozen = (stop_mode && st_r.ctrl.stop_frz)
      || (standby_mode && st_r.ctrl.stdby_frz)
      || (debug_halt && debug_halt_counter);
    rd_word = `WDG_RDATA_RESET;
    rd_word[`WDG_KEY_MSB:`WDG_KEY_LSB] = `WDG_KEY_VALUE;
    rd_word[`WDG_EN_BIT] = enabled;
    rd_word[`WDG_CKSEL_BIT] = st_r.ctrl.stop_cksel;
    rd_word[`WDG_STDBY_FRZ_BIT] = st_r.ctrl.stdby_frz;
    rd_word[`WDG_STOP_FRZ_BIT] = st_r.ctrl.stop_frz;
    rd_word[`WDG_PR_MSB:`WDG_PR_LSB] = st_r.ctrl.presc;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Slow oscillator sampling and source pick.

  always_comb
  begin
    int_tick = st_r.int_s2 && !st_r.int_s3;
    ext_tick = st_r.ext_s2 && !st_r.ext_s3;
    use_ext = standby_mode || st_r.ctrl.stop_cksel;
  end

  assign presc_link.src_tick = use_ext ? ext_tick : int_tick;
  assign presc_link.run = enabled && !frozen && (st_r.mode != watchdog_pkg::MODE_FIRED);
  assign presc_link.restart = !enabled || key_hit;
  assign presc_link.sel = st_r.ctrl.presc;

  watchdog_prescaler #(
    .PRESC_W(`WDG_PRESC_W)
  ) u_prescaler (
    .sys_clk(sys_clk),
    .reset(reset),
    .bus(presc_link)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb
  begin
    st_nxt = st_r;
    // Oscillators are foreign to sys_clk; stage one feeds stage two only.
    st_nxt.int_s1 = internal_slow_osc;
    st_nxt.int_s2 = st_r.int_s1;
    st_nxt.int_s3 = st_r.int_s2;
    st_nxt.ext_s1 = external_slow_osc;
    st_nxt.ext_s2 = st_r.ext_s1;
    st_nxt.ext_s3 = st_r.ext_s2;

    if (wr_acc)
    begin
      st_nxt.ctrl.en = pwdata[`WDG_EN_BIT];
      st_nxt.ctrl.stop_cksel = pwdata[`WDG_CKSEL_BIT];
      st_nxt.ctrl.stdby_frz = pwdata[`WDG_STDBY_FRZ_BIT];
      st_nxt.ctrl.stop_frz = pwdata[`WDG_STOP_FRZ_BIT];
      st_nxt.ctrl.presc = pwdata[`WDG_PR_MSB:`WDG_PR_LSB];
    end

    // Read data is captured in the setup phase so it comes from a flop in the access phase.
    if (psel && !penable && !pwrite)
    begin
      st_nxt.rdata = addr_hit ? rd_word : `WDG_RDATA_RESET;
    end

    unique case (st_r.mode)
      watchdog_pkg::MODE_IDLE,
      watchdog_pkg::MODE_COUNT,
      watchdog_pkg::MODE_HOLD:
      begin
        if (!enabled)
        begin
          st_nxt.mode = watchdog_pkg::MODE_IDLE;
          st_nxt.count = `WDG_COUNT_INIT;
        end
        else if (key_hit)
        begin
          st_nxt.count = `WDG_COUNT_INIT;
          st_nxt.mode = frozen ? watchdog_pkg::MODE_HOLD : watchdog_pkg::MODE_COUNT;
        end
        else if (frozen)
        begin
          st_nxt.mode = watchdog_pkg::MODE_HOLD;
        end
        else
        begin
          st_nxt.mode = watchdog_pkg::MODE_COUNT;
          if (presc_link.step)
          begin
            if (st_r.count == `WDG_COUNT_ZERO)
            begin
              // The step taken at zero is the 4096th, which closes the timeout.
              st_nxt.mode = watchdog_pkg::MODE_FIRED;
            end
            else
            begin
              st_nxt.count = st_r.count - `WDG_COUNT_W'(1);
            end
          end
        end
      end
      watchdog_pkg::MODE_FIRED:
      begin
        // Held until the device reset it requested comes back through reset.
        st_nxt.mode = watchdog_pkg::MODE_FIRED;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      st_r.int_s1 <= 1'b0;
      st_r.int_s2 <= 1'b0;
      st_r.int_s3 <= 1'b0;
      st_r.ext_s1 <= 1'b0;
      st_r.ext_s2 <= 1'b0;
      st_r.ext_s3 <= 1'b0;
      st_r.ctrl <= '0;
      st_r.count <= `WDG_COUNT_INIT;
      st_r.mode <= watchdog_pkg::MODE_IDLE;
      st_r.rdata <= `WDG_RDATA_RESET;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign prdata = st_r.rdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_hit;
  assign watchdog_reset_req = (st_r.mode == watchdog_pkg::MODE_FIRED);
  assign count_value = st_r.count;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  AST_DISABLED_HOLDS_INIT: assert property (
    (!enabled && !watchdog_reset_req) |=> (count_value == 12'hfff))
  else $error("disabled watchdog did not hold its counter at all ones");

  AST_KEY_RELOADS: assert property (
    (key_hit && enabled && !watchdog_reset_req) |=> (count_value == 12'hfff) && !watchdog_reset_req)
  else $error("key write did not reload the counter");

  AST_STEP_DECREMENTS: assert property (
    (presc_link.step && enabled && !frozen && !key_hit && (count_value != 12'h000)
      && (st_r.mode != watchdog_pkg::MODE_FIRED))
    |=> (count_value == $past(count_value) - 12'h001))
  else $error("counter did not decrement by one on a prescaler step");

  AST_FIRE_AT_ZERO: assert property (
    (presc_link.step && enabled && !frozen && !key_hit && (count_value == 12'h000))
    |=> watchdog_reset_req [*2])
  else $error("counter at zero did not raise a lasting reset request");

  AST_NO_RESET_WHEN_DISABLED: assert property (
    (!enabled && !watchdog_reset_req) |=> !watchdog_reset_req)
  else $error("reset request raised while the watchdog was disabled");

  AST_KEY_READS_PATTERN: assert property (
    (psel && penable && !pwrite && addr_hit && $past(psel) && !$past(penable))
    |-> (prdata[15:12] == 4'ha) && (prdata[11:9] == 3'h0))
  else $error("key field or reserved bits read wrong");

  AST_STOP_FREEZE: assert property (
    (stop_mode && st_r.ctrl.stop_frz && enabled && !key_hit) |=> $stable(count_value))
  else $error("counter moved while frozen in stop mode");

  AST_STANDBY_FREEZE: assert property (
    (standby_mode && st_r.ctrl.stdby_frz && enabled && !key_hit) |=> $stable(count_value))
  else $error("counter moved while frozen in standby");

  AST_DEBUG_FREEZE: assert property (
    (debug_halt && debug_halt_counter && enabled && !key_hit) |=> $stable(count_value))
  else $error("counter moved during debug halt with freeze chosen");

  AST_SOURCE_PICK: assert property (
    standby_mode |-> (presc_link.src_tick == ext_tick))
  else $error("standby did not force the external slow oscillator");

  AST_UNMAPPED_ERROR: assert property (
    (psel && penable && !addr_hit) |-> pslverr && pready)
  else $error("unmapped access was not answered with an error");

  AST_ENABLE_READBACK: assert property (
    (psel && !penable && !pwrite && addr_hit) |=> (prdata[8] == $past(enabled)))
  else $error("enable bit read back wrong");

  AST_FIRED_STICKY: assert property (
    watchdog_reset_req |=> watchdog_reset_req)
  else $error("reset request dropped before a reset");

  AST_FIRED_COUNT_HELD: assert property (
    watchdog_reset_req |=> $stable(count_value))
  else $error("counter moved after the reset request was raised");

  AST_FIRE_NEEDS_STEP: assert property (
    $rose(watchdog_reset_req) |-> $past(presc_link.step) && $past(enabled) && ($past(count_value) == 12'h000))
  else $error("reset request raised without a step at zero while enabled");

  AST_NO_STEP_NO_MOVE: assert property (
    (enabled && !key_hit && !presc_link.step && !watchdog_reset_req) |=> $stable(count_value))
  else $error("counter moved without a prescaler step");

  AST_SOURCE_INTERNAL: assert property (
    (!standby_mode && !st_r.ctrl.stop_cksel) |-> (presc_link.src_tick == int_tick))
  else $error("internal slow oscillator not selected");

  AST_SOURCE_EXTERNAL: assert property (
    (!standby_mode && st_r.ctrl.stop_cksel) |-> (presc_link.src_tick == ext_tick))
  else $error("external slow oscillator not selected");

  AST_RESERVED_ZERO: assert property (
    (psel && penable && !pwrite && $past(psel) && !$past(penable))
    |-> (prdata[31:16] == 16'h0000) && !prdata[7] && !prdata[3])
  else $error("reserved read bits were not zero");

  AST_WRITE_STORES: assert property (
    wr_acc |=> (st_r.ctrl.en == $past(pwdata[8])) && (st_r.ctrl.presc == $past(pwdata[2:0])))
  else $error("enable or prescale field not stored by a write");

  AST_WRITE_STORES_MODES: assert property (
    wr_acc |=> (st_r.ctrl.stop_frz == $past(pwdata[4])) && (st_r.ctrl.stdby_frz == $past(pwdata[5]))
      && (st_r.ctrl.stop_cksel == $past(pwdata[6])))
  else $error("freeze or clock select field not stored by a write");

  AST_UNMAPPED_NO_WRITE: assert property (
    (psel && penable && pwrite && !addr_hit) |=> $stable(st_r.ctrl))
  else $error("write to an unmapped address changed the control fields");

endmodule : independent_watchdog

// >>> test_independent_watchdog.sv
// Self-checking bench for the independent watchdog: register access, counting, freezing and timeout.
`timescale 1ns/10ps
`include "watchdog_regs.svh"

module test_independent_watchdog;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic int_osc = 1'b0;
  logic ext_osc = 1'b0;
  logic stop_mode = 1'b0;
  logic standby_mode = 1'b0;
  logic debug_halt = 1'b0;
  logic dbg_frz = 1'b0;
  logic strap = 1'b0;
  logic req;
  logic [11:0] cnt;
  logic [11:0] c0;
  logic [31:0] rd;
  logic [31:0] v;
  logic err;
  logic rdy;
  logic int_on = 1'b1;
  logic ext_on = 1'b1;
  logic ph = 1'b0;
  int error_cnt = 0;
  int n_compared = 0;
  int seed = 93666;
  int i;
  int k;

  independent_watchdog independent_watchdog_inst (
    .sys_clk(sys_clk),
    .reset(reset),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .internal_slow_osc(int_osc),
    .external_slow_osc(ext_osc),
    .stop_mode(stop_mode),
    .standby_mode(standby_mode),
    .debug_halt(debug_halt),
    .debug_halt_counter(dbg_frz),
    .hw_start_option(strap),
    .watchdog_reset_req(req),
    .count_value(cnt)
  );

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end

  // Both slow oscillators run at a quarter of the bus clock so a counter step takes eight cycles at the fastest division.
  initial
  begin
    forever
    begin
      @(posedge sys_clk);
      #1;
      if (ph)
      begin
        int_osc = int_on ? ~int_osc : int_osc;
        ext_osc = ext_on ? ~ext_osc : ext_osc;
      end
      ph = ~ph;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] exp_rd(input logic [31:0] w, input logic s);
    return {16'h0000, 4'ha, 3'b000, w[8] | s, 1'b0, w[6:4], 1'b0, w[2:0]};
  endfunction : exp_rd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    #1;
    psel = 1'b1;
    pwrite = wr;
    paddr = a;
    pwdata = d;
    @(posedge sys_clk);
    #1;
    penable = 1'b1;
    @(posedge sys_clk);
    rd = prdata;
    err = pslverr;
    rdy = pready;
    #1;
    psel = 1'b0;
    penable = 1'b0;
  endtask : apb

  // The flush delay lets a new setting pass the oscillator synchronisers before sampling.
  task automatic moves(input logic exp);
    cyc(20);
    c0 = cnt;
    cyc(120);
    chk(cnt !== c0, exp);
  endtask : moves

  task automatic wait_chg();
    c0 = cnt;
    k = 0;
    while (cnt === c0 && k < 4000)
    begin
      cyc(1);
      k++;
    end
  endtask : wait_chg

  task automatic summarize();
    $display("errors=%0d compared=%0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    error_cnt++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    summarize();
  end

  initial
  begin
    cyc(2);
    reset = 1'b0;
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk(rd, 32'h0000_a000);
    chk(cnt, `WDG_COUNT_INIT);
    for (i = 0; i < 8; i++)
    begin
      v = $random(seed) & 32'hffff_0eff;
      apb(1'b1, 12'h000, v);
      apb(1'b0, 12'h000, 32'h0000_0000);
      chk(rd, exp_rd(v, 1'b0));
      chk(err, 1'b0);
      chk(rdy, 1'b1);
      apb(1'b1, {$random(seed)} % 4095 + 1, 32'h0000_a100);
      apb(1'b0, {$random(seed)} % 4095 + 1, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      chk(err, 1'b1);
      cyc(30);
      chk(cnt, `WDG_COUNT_INIT);
    end
    // Clear the stored fields so the strap runs at the fastest division and reads back plainly.
    apb(1'b1, 12'h000, 32'h0000_0000);
    strap = 1'b1;
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk(rd, exp_rd(32'h0000_0000, 1'b1));
    moves(1'b1);
    strap = 1'b0;
    apb(1'b1, 12'h000, 32'h0000_a000);
    cyc(2);
    chk(cnt, `WDG_COUNT_INIT);
    apb(1'b1, 12'h000, 32'h0000_a100);
    for (i = 0; i < 6; i++)
    begin
      cyc(20 + ({$random(seed)} % 256));
      apb(1'b1, 12'h000, 32'h0000_a100 | ({$random(seed)} % 8));
      chk({req, cnt}, {1'b0, `WDG_COUNT_INIT});
    end
    for (i = 0; i < 8; i++)
    begin
      apb(1'b1, 12'h000, 32'h0000_a100 | i);
      wait_chg();
      wait_chg();
      chk(k, 8 << i);
    end
    // Each mode is tried frozen, then with its freeze control off.
    for (i = 0; i < 6; i++)
    begin
      stop_mode = (i % 3 == 0);
      standby_mode = (i % 3 == 1);
      debug_halt = (i % 3 == 2);
      dbg_frz = (i == 2);
      apb(1'b1, 12'h000, 32'h0000_a100 | (i == 0 ? 32'h10 : 32'h0) | (i == 1 ? 32'h20 : 32'h0));
      moves(i > 2);
    end
    debug_halt = 1'b0;
    ext_on = 1'b0;
    apb(1'b1, 12'h000, 32'h0000_a100);
    moves(1'b1);
    apb(1'b1, 12'h000, 32'h0000_a140);
    moves(1'b0);
    ext_on = 1'b1;
    int_on = 1'b0;
    moves(1'b1);
    apb(1'b1, 12'h000, 32'h0000_a100);
    moves(1'b0);
    standby_mode = 1'b1;
    moves(1'b1);
    standby_mode = 1'b0;
    int_on = 1'b1;
    apb(1'b1, 12'h000, 32'h0000_a100);
    cyc(4096 * 8 - 24);
    chk(req, 1'b0);
    k = 0;
    while (req !== 1'b1 && k < 60)
    begin
      cyc(1);
      k++;
    end
    chk({req, cnt}, {1'b1, `WDG_COUNT_ZERO});
    apb(1'b1, 12'h000, 32'h0000_a100);
    chk(req, 1'b1);
    reset = 1'b1;
    cyc(2);
    reset = 1'b0;
    cyc(1);
    chk({req, cnt}, {1'b0, `WDG_COUNT_INIT});
    summarize();
  end
endmodule : test_independent_watchdog
